// *** verif/undervoltage_alarm_monitor_test.sv ***
/* Self-checking bench for the alarm monitor, with expected values worked out in the sequence.
   Assumes the host model and bound checker are compiled before it. */
`timescale 1ns/10ps
module undervoltage_alarm_monitor_test;
  localparam int T  = 20;
  localparam int NR = uvam_pkg::NUM_REFS;
  localparam int VW = uvam_pkg::VOLT_W;
  logic             clock, rst_b, hsel, hwrite, hreadyout, hresp, alarmOut, irq, anyEn;
  logic [1:0]       htrans, lamp;
  logic [2:0]       hsize;
  logic [31:0]      haddr, hwdata, hrdata, rd;
  logic [NR-1:0]    en, expMask;
  logic [NR*VW-1:0] vRms;
  int               err_count, n_checks, seed, irqCount, pw[8], thr[NR], vv[NR];

  uvam_top #(.TICK_CYCLES(T)) dut_u (
    .clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .vRms(vRms),
    .alarmOut(alarmOut), .irq(irq));
  uvam_host_model host_u (.clock(clock), .rst_b(rst_b), .alarmOut(alarmOut), .irq(irq),
    .anyEn(anyEn), .irqCount(irqCount), .lamp(lamp));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ==========================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Ready is looked at mid-cycle; it only moves after rising edges
  task automatic bus(input logic w, input logic [13:0] idx, input logic [31:0] d);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'h2;
    haddr  <= {16'h0000, idx, 2'b00};
    do @(negedge clock); while (!hreadyout);
    @(posedge clock);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(negedge clock); while (!hreadyout);
    rd = hrdata;
  endtask
  task automatic wr(input logic [13:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rdc(input string nm, input logic [13:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic setV(input logic low);
    @(posedge clock);
    for (int k = 0; k < NR; k++) vRms[k*VW +: VW] <= low ? VW'(vv[k]) : 16'hffff;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    test_done();
  end
  // ==========================================
  // Main sequence
  initial begin
    {rst_b, hsel, hwrite, anyEn} = 4'h0;
    {haddr, hwdata, htrans, hsize, en} = '0;
    vRms = '1;
    seed = 56;
    err_count = 0;
    n_checks = 0;
    pw = '{5, 14, 15, 37, 60, 61, 63, 256};
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    wt(3);
    chk("alarm", 32'(alarmOut), 32'h0);
    chk("irq", 32'(irq), 32'h0);
    chk("lamp", 32'(lamp), 32'h0);
    rdc("persist", uvam_pkg::IDX_PERSIST, 32'h0000000f);
    rdc("enable", uvam_pkg::IDX_ENABLE, 32'h0);
    rdc("intEn", uvam_pkg::IDX_INT_ENABLE, 32'h0);
    rdc("status", uvam_pkg::IDX_ALARM_STATUS, 32'h0);
    rdc("thr0", uvam_pkg::IDX_THRESH_FIRST, 32'h0);
    rdc("unmapped", 14'h0001, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(uvam_pkg::IDX_PERSIST, 32'(pw[i]));
      rdc("persist", uvam_pkg::IDX_PERSIST, 32'(pw[i] < 15 ? 15 : (pw[i] > 60 ? 60 : pw[i])));
    end
    wr(uvam_pkg::IDX_PERSIST, 32'h0000000f);
    // Voltages straddle each threshold by one volt to catch the strict compare
    en = NR'($random(seed)) | 1;
    for (int k = 0; k < NR; k++) begin
      thr[k] = host_u.clampThr(k, 1 + ($random(seed) & 32'h3ff));
      vv[k] = (k == 0) ? thr[k] - 1 : thr[k] + ($random(seed) & 32'h7fff) % 3 - 1;
      expMask[k] = en[k] && (vv[k] < thr[k]);
      wr(14'(uvam_pkg::IDX_THRESH_FIRST + k), 32'(thr[k]));
      rdc("thr", 14'(uvam_pkg::IDX_THRESH_FIRST + k), 32'(thr[k]));
    end
    wr(uvam_pkg::IDX_ENABLE, 32'(en));
    wr(uvam_pkg::IDX_COMMIT, 32'h0);
    rdc("activeEn", uvam_pkg::IDX_ACTIVE_EN, 32'h0);
    setV(1'b1);
    wt(16 * T);
    chk("alarm", 32'(alarmOut), 32'h0);
    setV(1'b0);
    wr(uvam_pkg::IDX_COMMIT, 32'h1);
    anyEn = |en;
    rdc("activeEn", uvam_pkg::IDX_ACTIVE_EN, 32'(en));
    wr(uvam_pkg::IDX_INT_ENABLE, 32'h00000fff);
    setV(1'b1);
    wt(10 * T);
    setV(1'b0);
    wt(2 * T);
    setV(1'b1);
    wt(14 * T - 5);
    chk("alarm", 32'(alarmOut), 32'h0);
    chk("lamp", 32'(lamp), 32'h1);
    wt(T + 10);
    chk("alarm", 32'(alarmOut), 32'h1);
    chk("lamp", 32'(lamp), 32'h2);
    rdc("status", uvam_pkg::IDX_ALARM_STATUS, 32'(expMask));
    rdc("intStatus", uvam_pkg::IDX_INT_STATUS, 32'(expMask));
    chk("irq", 32'(irq), 32'h1);
    chk("irqCount", 32'(irqCount), 32'h1);
    wr(uvam_pkg::IDX_INT_ENABLE, 32'h0);
    wt(4);
    chk("irq", 32'(irq), 32'h0);
    rdc("intStatus", uvam_pkg::IDX_INT_STATUS, 32'(expMask));
    wr(uvam_pkg::IDX_INT_CLEAR, 32'h00000fff);
    rdc("intStatus", uvam_pkg::IDX_INT_STATUS, 32'h0);
    wr(uvam_pkg::IDX_INT_ENABLE, 32'h00000fff);
    wt(4);
    chk("irq", 32'(irq), 32'h0);
    setV(1'b0);
    wt(T + 5);
    chk("alarm", 32'(alarmOut), 32'h0);
    rdc("status", uvam_pkg::IDX_ALARM_STATUS, 32'h0);
    setV(1'b1);
    wt(15 * T + 5);
    chk("alarm", 32'(alarmOut), 32'h1);
    chk("irqCount", 32'(irqCount), 32'h2);
    wr(uvam_pkg::IDX_ENABLE, 32'h0);
    wr(uvam_pkg::IDX_COMMIT, 32'h1);
    anyEn = 1'b0;
    wt(T + 5);
    chk("alarm", 32'(alarmOut), 32'h0);
    chk("lamp", 32'(lamp), 32'h0);
    rdc("activeEn", uvam_pkg::IDX_ACTIVE_EN, 32'h0);
    test_done();
  end
endmodule

// *** verif/uvam_alarm_monitor.sv ***
/* Checker on the top ports of the alarm monitor, bound into uvam_top.
   Assumes hready is tied to hreadyout and persistence never below its minimum. */
`timescale 1ns/10ps
module uvam_alarm_monitor #(
  parameter int unsigned TICK_CYCLES = 20
) (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        alarmOut,
  input wire logic        irq
);
  // Small margins absorb the two-cycle lag between tick and pin
  localparam int LOW_MIN  = int'(uvam_pkg::PERSIST_MIN) * int'(TICK_CYCLES) - 2;
  localparam int HOLD_MIN = int'(TICK_CYCLES) - 1;
  logic rdTk;
  logic wrTk;
  int   runLen;
  assign rdTk = hsel & htrans[1] & hready & ~hwrite;
  assign wrTk = hsel & htrans[1] & hready & hwrite;
  // ==========================================
  // Length of the current alarm level
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      runLen <= 0;
    else if ($changed(alarmOut))
      runLen <= 1;
    else if (runLen < 1000000)
      runLen <= runLen + 1;
  end
  // ==========================================
  // Properties
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (rdTk |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (wrTk |=> hreadyout)
    else $error("write stalled");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(rdTk, 2))
    else $error("read data changed without a read");
  a_alarm_persist: assert property ($rose(alarmOut) |-> runLen >= LOW_MIN)
    else $error("alarm rose before persistence time");
  a_alarm_tick_hold: assert property ($fell(alarmOut) |-> runLen >= HOLD_MIN)
    else $error("alarm shorter than one evaluation period");
  a_irq_rise_cause: assert property ($rose(irq) |-> alarmOut || $past(wrTk, 2)
    || $past(wrTk, 3) || $past(wrTk, 4))
    else $error("interrupt rose without alarm or write");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(wrTk, 2)
    || $past(wrTk, 3) || $past(wrTk, 4))
    else $error("interrupt fell without a write");
  cover property ($rose(alarmOut));
  cover property ($fell(irq));
  cover property (rdTk ##2 $changed(hrdata));
endmodule

bind uvam_top uvam_alarm_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon_u (
  .clock(clock), .rst_b(rst_b), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .alarmOut(alarmOut), .irq(irq));

// *** verif/uvam_host_model.sv ***
/* Host partner: interrupt input, alarm indicator and threshold entry.
   Assumes irq and alarmOut are synchronous to clock. */
`timescale 1ns/10ps
module uvam_host_model (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       alarmOut,
  input  wire logic       irq,
  input  wire logic       anyEn,
  output int              irqCount,
  output logic [1:0]      lamp
);
  localparam logic [1:0] LAMP_DARK  = 2'h0;
  localparam logic [1:0] LAMP_GREEN = 2'h1;
  localparam logic [1:0] LAMP_RED   = 2'h2;
  logic irqPrev;
  // Entry clamps rather than refuses; first three refs of each input are neutral
  function automatic int clampThr(input int refIdx, input int v);
    int lim;
    lim = (refIdx % 6 < 3) ? 350 : 600;
    return (v > lim) ? lim : v;
  endfunction
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irqPrev  <= 1'b0;
      irqCount <= 0;
    end else begin
      irqPrev <= irq;
      if (irq && !irqPrev)
        irqCount <= irqCount + 1;
    end
  end
  assign lamp = alarmOut ? LAMP_RED : (anyEn ? LAMP_GREEN : LAMP_DARK);
endmodule

// *** verilog/uvam_pkg.sv ***
/*
 * Constants, register map and types of the under-voltage alarm monitor.
 * Assumes a 200 MHz system clock and a word-wide AHB-Lite register bus.
 */
package uvam_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLOCK_HZ     = 200_000_000;
  localparam int unsigned TICK_SECONDS = 1;
  localparam int unsigned TICK_CYCLES  = TICK_SECONDS * CLOCK_HZ;

  // ==========================================================================
  // Sizes
  localparam int NUM_INPUTS     = 2;
  localparam int REFS_PER_INPUT = 6;
  localparam int NUM_REFS       = NUM_INPUTS * REFS_PER_INPUT;
  localparam int VOLT_W         = 16;
  localparam int PERSIST_W      = 6;
  localparam int INDEX_W        = 14;

  // ==========================================================================
  // Persistence range in seconds
  localparam logic [PERSIST_W-1:0] PERSIST_MIN   = 6'h0f;
  localparam logic [PERSIST_W-1:0] PERSIST_MAX   = 6'h3c;
  localparam logic [PERSIST_W-1:0] PERSIST_RESET = 6'h0f;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [INDEX_W-1:0] IDX_ALARM_STATUS = 14'h0992;
  localparam logic [INDEX_W-1:0] IDX_ENABLE       = 14'h0993;
  localparam logic [INDEX_W-1:0] IDX_PERSIST      = 14'h0994;
  localparam logic [INDEX_W-1:0] IDX_COMMIT       = 14'h0995;
  localparam logic [INDEX_W-1:0] IDX_ACTIVE_EN    = 14'h0996;
  localparam logic [INDEX_W-1:0] IDX_INT_STATUS   = 14'h0997;
  localparam logic [INDEX_W-1:0] IDX_INT_CLEAR    = 14'h0998;
  localparam logic [INDEX_W-1:0] IDX_INT_ENABLE   = 14'h0999;
  localparam logic [INDEX_W-1:0] IDX_THRESH_FIRST = 14'h099c;
  localparam logic [INDEX_W-1:0] IDX_BLOCK_LAST   = 14'h09c4;

  localparam int COMMIT_BIT = 0;

  // ==========================================================================
  // Reset values
  localparam logic [NUM_REFS-1:0] ENABLE_RESET     = 12'h000;
  localparam logic [NUM_REFS-1:0] INT_ENABLE_RESET = 12'h000;
  localparam logic [VOLT_W-1:0]   THRESH_RESET     = 16'h0000;

  // ==========================================================================
  // Per-reference evaluation state
  typedef enum logic [2:0] {
    UVAM_ST_WATCH = 3'b001,
    UVAM_ST_COUNT = 3'b010,
    UVAM_ST_ALARM = 3'b100
  } uvam_ref_state_t;

endpackage

// *** verilog/uvam_ref_monitor.sv ***
/*
 * Persistence filter for one voltage reference.
 * Assumes tick is a one-cycle pulse and inputs are stable around it.
 */
`timescale 1ns/10ps

module uvam_ref_monitor (
  input  wire logic                           clock,
  input  wire logic                           rstB,
  input  wire logic                           tick,
  input  wire logic                           enable,
  input  wire logic [uvam_pkg::VOLT_W-1:0]    measured,
  input  wire logic [uvam_pkg::VOLT_W-1:0]    threshold,
  input  wire logic [uvam_pkg::PERSIST_W-1:0] persist,
  output logic                                alarm,
  output logic                                raise
);

  uvam_pkg::uvam_ref_state_t        state;
  logic [uvam_pkg::PERSIST_W-1:0]   count;
  logic                             below;
  logic [uvam_pkg::PERSIST_W-1:0]   nextCount;

  assign below     = enable && (measured < threshold);
  assign nextCount = count + 1'b1;
  assign alarm     = (state == uvam_pkg::UVAM_ST_ALARM);

  // ==========================================================================
  // Evaluation once per tick
  always_ff @(posedge clock or negedge rstB) begin
    if (!rstB) begin
      state <= uvam_pkg::UVAM_ST_WATCH;
      count <= '0;
      raise <= 1'b0;
    end else begin
      raise <= 1'b0;
      if (tick) begin
        if (!below) begin
          // Any clean sample restarts the filter and drops the alarm
          state <= uvam_pkg::UVAM_ST_WATCH;
          count <= '0;
        end else begin
          case (state)
            uvam_pkg::UVAM_ST_ALARM: begin
              state <= uvam_pkg::UVAM_ST_ALARM;
            end
            uvam_pkg::UVAM_ST_WATCH,
            uvam_pkg::UVAM_ST_COUNT: begin
              if (nextCount >= persist) begin
                state <= uvam_pkg::UVAM_ST_ALARM;
                count <= '0;
                raise <= 1'b1;
              end else begin
                state <= uvam_pkg::UVAM_ST_COUNT;
                count <= nextCount;
              end
            end
            default: begin
              state <= uvam_pkg::UVAM_ST_WATCH;
              count <= '0;
            end
          endcase
        end
      end
    end
  end

endmodule

// *** verilog/uvam_tick_gen.sv ***
/*
 * Divider producing a one-cycle evaluation enable once per period.
 * Assumes an asynchronous active-low reset whose release is already synchronous to clock.
 */
`timescale 1ns/10ps

module uvam_tick_gen #(
  parameter int unsigned CYCLES = uvam_pkg::TICK_CYCLES
) (
  input  wire logic clock,
  input  wire logic rstB,
  output logic      tick
);

  localparam int CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] count;

  // ==========================================================================
  // Free-running period counter
  always_ff @(posedge clock or negedge rstB) begin
    if (!rstB) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count == LAST) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule

// *** verilog/uvam_top.sv ***
/*
 * Under-voltage alarm monitor: register file on AHB-Lite, per-reference
 * persistence filters, alarm pin and interrupt.
 * Assumes RMS voltages arrive as integer volts synchronous to clock, one
 * field per reference, input 0 references first (L1-N, L2-N, L3-N,
 * L1-L2, L2-L3, L3-L1).
 */
// Chosen here: register access over AHB-Lite and the register offsets.
//
// Overview of operation
// - Every enabled reference is evaluated once per second on a divided tick.
// - A reference is in alarm condition when its RMS voltage is below its threshold.
// - The persistence time is held in a register adjustable from 15 to 60 seconds.
// - An alarm triggers only after the condition holds for the whole persistence time.
// - Each input has line-to-neutral and line-to-line references, one integer threshold each.
// - A reference is evaluated only when enabled and its settings have been committed.
// - A dedicated alarm output rests low and goes high while any alarm is present.
// - Status registers in the alarm block show which reference is in alarm.
// - Alarms are not latched and clear themselves once the voltage recovers.
`timescale 1ns/10ps

module uvam_top #(
  parameter int unsigned TICK_CYCLES = uvam_pkg::TICK_CYCLES,
  parameter int          NUM_REFS    = uvam_pkg::NUM_REFS
) (
  input  wire logic                               clock,
  input  wire logic                               rst_b,
  input  wire logic                               hsel,
  input  wire logic [31:0]                        haddr,
  input  wire logic [1:0]                         htrans,
  input  wire logic                               hwrite,
  input  wire logic [2:0]                         hsize,
  input  wire logic [31:0]                        hwdata,
  input  wire logic                               hready,
  output logic                                    hreadyout,
  output logic                                    hresp,
  output logic [31:0]                             hrdata,
  input  wire logic [NUM_REFS*uvam_pkg::VOLT_W-1:0] vRms,
  output logic                                    alarmOut,
  output logic                                    irq
);

  localparam int VW = uvam_pkg::VOLT_W;
  localparam int PW = uvam_pkg::PERSIST_W;
  localparam int IW = uvam_pkg::INDEX_W;

  // ==========================================================================
  // Reset release
  logic rstMeta;
  logic rstB;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstB    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstB    <= rstMeta;
    end
  end

  // ==========================================================================
  // Declarations
  logic [NUM_REFS-1:0] enableStaged;
  logic [NUM_REFS-1:0] enableActive;
  logic [VW-1:0]       threshStaged [NUM_REFS];
  logic [VW-1:0]       threshActive [NUM_REFS];
  logic [PW-1:0]       persist;
  logic [NUM_REFS-1:0] intStatus;
  logic [NUM_REFS-1:0] intEnable;
  logic [NUM_REFS-1:0] alarmVec;
  logic [NUM_REFS-1:0] raiseVec;
  logic                tick;

  logic                accept;
  logic                wrPending;
  logic                rdPending;
  logic                rdDone;
  logic [IW-1:0]       wrIndex;
  logic [IW-1:0]       rdIndex;
  logic [IW-1:0]       addrIndex;

  logic                wrEn;
  logic                commitPulse;
  logic [NUM_REFS-1:0] clearMask;
  logic [31:0]         next_hrdata;
  logic [PW-1:0]       next_persist;
  logic                wrEnable;
  logic                wrPersist;
  logic                wrIntClear;
  logic                wrIntEnable;
  logic [NUM_REFS-1:0] wrThresh;
  logic [NUM_REFS-1:0] rdThresh;

  // ==========================================================================
  // AHB-Lite slave: writes take no wait state; reads take one so that a
  // read straight after a write sees the new value
  assign addrIndex = haddr[IW+1:2];
  assign accept    = hsel && htrans[1] && hready;
  assign hreadyout = !(rdPending && !rdDone);
  assign hresp     = 1'b0;
  assign wrEn      = wrPending;

  always_ff @(posedge clock or negedge rstB) begin
    if (!rstB) begin
      wrPending <= 1'b0;
      rdPending <= 1'b0;
      rdDone    <= 1'b0;
      wrIndex   <= '0;
      rdIndex   <= '0;
    end else begin
      if (hready) begin
        wrPending <= accept && hwrite;
        rdPending <= accept && !hwrite;
        rdDone    <= 1'b0;
        if (accept) begin
          wrIndex <= addrIndex;
          rdIndex <= addrIndex;
        end
      end else if (rdPending) begin
        rdDone <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Register decode; writes land in the data phase, reads in the wait state
  assign wrEnable    = wrEn && (wrIndex == uvam_pkg::IDX_ENABLE);
  assign wrPersist   = wrEn && (wrIndex == uvam_pkg::IDX_PERSIST);
  assign wrIntClear  = wrEn && (wrIndex == uvam_pkg::IDX_INT_CLEAR);
  assign wrIntEnable = wrEn && (wrIndex == uvam_pkg::IDX_INT_ENABLE);

  // Threshold slots are contiguous, one word per reference
  always_comb begin
    for (int i = 0; i < NUM_REFS; i++) begin
      wrThresh[i] = wrEn && (wrIndex == uvam_pkg::IDX_THRESH_FIRST + IW'(i));
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_REFS; i++) begin
      rdThresh[i] = (rdIndex == uvam_pkg::IDX_THRESH_FIRST + IW'(i));
    end
  end

  // ==========================================================================
  // Read mux, loaded into hrdata during the read wait state
  always_comb begin
    next_hrdata = 32'h0000_0000;
    case (rdIndex)
      uvam_pkg::IDX_ALARM_STATUS: next_hrdata[NUM_REFS-1:0] = alarmVec;
      uvam_pkg::IDX_ENABLE:       next_hrdata[NUM_REFS-1:0] = enableStaged;
      uvam_pkg::IDX_PERSIST:      next_hrdata[PW-1:0]       = persist;
      uvam_pkg::IDX_ACTIVE_EN:    next_hrdata[NUM_REFS-1:0] = enableActive;
      uvam_pkg::IDX_INT_STATUS:   next_hrdata[NUM_REFS-1:0] = intStatus;
      uvam_pkg::IDX_INT_ENABLE:   next_hrdata[NUM_REFS-1:0] = intEnable;
      default: begin
        for (int i = 0; i < NUM_REFS; i++) begin
          if (rdThresh[i]) begin
            next_hrdata[VW-1:0] = threshStaged[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstB) begin
    if (!rstB) begin
      hrdata <= 32'h0000_0000;
    end else if (rdPending && !rdDone) begin
      hrdata <= next_hrdata;
    end
  end

  // ==========================================================================
  // Staged enables and thresholds take effect only on a commit; persistence applies at once
  assign commitPulse = wrEn && (wrIndex == uvam_pkg::IDX_COMMIT)
                       && hwdata[uvam_pkg::COMMIT_BIT];

  always_ff @(posedge clock or negedge rstB) begin
    if (!rstB) begin
      enableStaged <= uvam_pkg::ENABLE_RESET;
    end else if (wrEnable) begin
      enableStaged <= hwdata[NUM_REFS-1:0];
    end
  end

  always_ff @(posedge clock or negedge rstB) begin
    if (!rstB) begin
      for (int i = 0; i < NUM_REFS; i++) begin
        threshStaged[i] <= uvam_pkg::THRESH_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_REFS; i++) begin
        if (wrThresh[i]) begin
          threshStaged[i] <= hwdata[VW-1:0];
        end
      end
    end
  end

  // Out-of-range persistence writes are pulled to the nearest limit
  always_comb begin
    if (hwdata[31:PW] != '0 || hwdata[PW-1:0] > uvam_pkg::PERSIST_MAX) begin
      next_persist = uvam_pkg::PERSIST_MAX;
    end else if (hwdata[PW-1:0] < uvam_pkg::PERSIST_MIN) begin
      next_persist = uvam_pkg::PERSIST_MIN;
    end else begin
      next_persist = hwdata[PW-1:0];
    end
  end

  always_ff @(posedge clock or negedge rstB) begin
    if (!rstB) begin
      persist <= uvam_pkg::PERSIST_RESET;
    end else if (wrPersist) begin
      persist <= next_persist;
    end
  end

  // ==========================================================================
  // Committed settings seen by the filters
  always_ff @(posedge clock or negedge rstB) begin
    if (!rstB) begin
      enableActive <= uvam_pkg::ENABLE_RESET;
      for (int i = 0; i < NUM_REFS; i++) begin
        threshActive[i] <= uvam_pkg::THRESH_RESET;
      end
    end else if (commitPulse) begin
      enableActive <= enableStaged;
      for (int i = 0; i < NUM_REFS; i++) begin
        threshActive[i] <= threshStaged[i];
      end
    end
  end

  // ==========================================================================
  // Evaluation tick and per-reference filters
  uvam_tick_gen #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clock (clock),
    .rstB  (rstB),
    .tick  (tick)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_REFS; g++) begin : gen_ref
      uvam_ref_monitor u_mon (
        .clock     (clock),
        .rstB      (rstB),
        .tick      (tick),
        .enable    (enableActive[g]),
        .measured  (vRms[g*VW +: VW]),
        .threshold (threshActive[g]),
        .persist   (persist),
        .alarm     (alarmVec[g]),
        .raise     (raiseVec[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Alarm pin and interrupt
  always_ff @(posedge clock or negedge rstB) begin
    if (!rstB) begin
      alarmOut <= 1'b0;
    end else begin
      alarmOut <= |alarmVec;
    end
  end

  assign clearMask = wrIntClear ? hwdata[NUM_REFS-1:0]
                                : '0;

  // A new raise in the clearing cycle survives the clear
  always_ff @(posedge clock or negedge rstB) begin
    if (!rstB) begin
      intStatus <= '0;
    end else begin
      intStatus <= (intStatus & ~clearMask) | raiseVec;
    end
  end

  always_ff @(posedge clock or negedge rstB) begin
    if (!rstB) begin
      intEnable <= uvam_pkg::INT_ENABLE_RESET;
    end else if (wrIntEnable) begin
      intEnable <= hwdata[NUM_REFS-1:0];
    end
  end

  always_ff @(posedge clock or negedge rstB) begin
    if (!rstB) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStatus & intEnable);
    end
  end

endmodule
